/* File: rtl/cpu_pkg.sv */
// Constants, types and register map of the processor core datapath.
// Assumes a single 250 MHz clock; all addresses are word or byte indices.
package cpu_pkg;
  localparam int          DW              = 24;
  localparam int          PCW             = 13;
  localparam int          RAM_WORDS       = 128;
  localparam int          NVM_BYTES       = 2048;
  localparam int          NVM_BLOCK       = 512;
  localparam int          USER_CODE_BYTES = 1952;
  localparam logic [12:0] ROM_BASE        = 13'h0800;
  localparam logic [12:0] ROM_TOP         = 13'h13FF;
  localparam logic [12:0] PROG_ENTRY      = 13'h0030;
  localparam logic [12:0] CODE_END        = 13'h07D0;
  localparam logic [10:0] USER_NVM_BASE   = 11'h7D0;
  localparam logic [3:0]  CFG_LAST        = 4'hF;
  localparam logic [3:0]  CFG_LOW_COUNT   = 4'hD;
  localparam logic [6:0]  CFG_RAM_BASE    = 7'h30;
  localparam logic [6:0]  CFG_HIGH_RAM    = 7'h40;
  localparam logic [6:0]  STATUS_ADDR     = 7'h16;
  localparam logic [6:0]  SCRATCH_BASE    = 7'h70;
  localparam int          CAUSE_LSB       = 15;
  localparam logic [4:0]  CAUSE_POR       = 5'h10;
  // Register offsets
  localparam logic [7:0]  REG_CMD         = 8'h00;
  localparam logic [7:0]  REG_OPND        = 8'h04;
  localparam logic [7:0]  REG_STAT        = 8'h08;
  localparam logic [7:0]  REG_CTRL        = 8'h0C;
  localparam logic [7:0]  REG_ACC_X       = 8'h10;
  localparam logic [7:0]  REG_ACC_Y       = 8'h14;
  localparam logic [7:0]  REG_ACC_Z       = 8'h18;
  localparam logic [7:0]  REG_ACC_RAM     = 8'h1C;
  // Command word fields
  localparam int          CMD_DST_LSB     = 5;
  localparam int          CMD_SRC_LSB     = 7;
  localparam int          CMD_COND_LSB    = 9;
  localparam int          CMD_ARG_LSB     = 11;
  // Status word fields
  localparam int          STAT_PTR_LSB    = 4;
  localparam int          STAT_PC_LSB     = 11;
  localparam int          STAT_RUN_BIT    = 24;

  typedef enum logic [4:0] {
    OP_NOP          = 5'h00,
    OP_MOVE         = 5'h01,
    OP_SWAP         = 5'h02,
    OP_ADD          = 5'h03,
    OP_SUB          = 5'h04,
    shift_left_op   = 5'h05,
    shift_right_op  = 5'h06,
    rotate_right_op = 5'h07,
    multiply_single_width_op = 5'h08,
    OP_LOAD         = 5'h09,
    OP_PTR_LOAD     = 5'h0A,
    OP_PTR_INC      = 5'h0B,
    OP_PTR_DEC      = 5'h0C,
    OP_JUMP         = 5'h0D,
    OP_JCOND        = 5'h0E,
    OP_CALL         = 5'h0F,
    OP_RET          = 5'h10,
    OP_ENTER        = 5'h11,
    OP_NVM_PUT      = 5'h12,
    OP_NVM_GET      = 5'h13
  } op_t;

  typedef enum logic [1:0] {
    ST_COPY = 2'b00,
    ST_FLAG = 2'b01,
    ST_RUN  = 2'b10
  } phase_t;
endpackage

/* File: rtl/alu_core.sv */
// Combinational 24-bit ALU: result, carry and overflow for one operation.
// Assumes operands are already selected from the four accumulators, the operand register or the byte store.
`timescale 1ns/10ps
module alu_core
  import cpu_pkg::*;
(
  input  wire op_t             op,
  input  wire logic [DW-1:0]   a,
  input  wire logic [DW-1:0]   b,
  input  wire logic            carry_in,
  output logic [DW-1:0]        res,
  output logic                 carry_out,
  output logic                 ovf_out,
  output logic                 writes_acc,
  output logic                 updates_cv
);
  logic [DW:0]     sum;
  logic [2*DW-1:0] prod;

  always_comb begin
    sum        = {1'b0, a} + {1'b0, b};
    prod       = a * b;
    res        = a;
    carry_out  = carry_in;
    ovf_out    = 1'b0;
    writes_acc = 1'b1;
    updates_cv = 1'b0;
    case (op)
      OP_MOVE, OP_SWAP, OP_LOAD, OP_NVM_GET: res = b;
      OP_ADD: begin
        {carry_out, res} = sum;
        ovf_out    = (a[DW-1] == b[DW-1]) && (sum[DW-1] != a[DW-1]);
        updates_cv = 1'b1;
      end
      OP_SUB: begin
        {carry_out, res} = {1'b0, a} - {1'b0, b};
        ovf_out    = (a[DW-1] != b[DW-1]) && (res[DW-1] != a[DW-1]);
        updates_cv = 1'b1;
      end
      shift_left_op: begin
        {carry_out, res} = {a, 1'b0};
        updates_cv       = 1'b1;
      end
      shift_right_op: begin
        res        = {a[DW-1], a[DW-1:1]};
        carry_out  = a[0];
        updates_cv = 1'b1;
      end
      rotate_right_op: begin
        res        = {a[0], a[DW-1:1]};
        carry_out  = a[0];
        updates_cv = 1'b1;
      end
      multiply_single_width_op: res = prod[DW-1:0];
      default: writes_acc = 1'b0;
    endcase
  end
endmodule

/* File: rtl/cpu_datapath.sv */
// Core datapath: program address map, power-on configuration copy,
// 24-bit RAM with pointer, three accumulators and four condition flags.
// Assumes a register port driven synchronously to clock.
//
// Summary of operation
// - Read-only routine area begins at program address 2048.
// - Nonvolatile program may call routines; return allowed when enabled.
// - Nonvolatile store holds 2048 bytes in four 512-byte blocks.
// - User code spans 1952 bytes starting at byte 48.
// - Every transfer from routine area into user program lands at 48.
// - Entry cause recorded in status word at RAM location 22.
// - Lowest 48 bytes form 16 words of three bytes each.
// - Power-on copies configuration words into RAM 48 to 60 and 64 to 66.
// - Cells 2000 to 2047 readable and writable through indices 0 to 15.
// - RAM has its own address, 128 words of 24 bits.
// - Pointed RAM word serves as fourth accumulator.
// - Pointer changes leave RAM untouched; only pointer ops alter it.
// - Three 24-bit accumulators X, Y and Z.
// - Move, swap and arithmetic work on all four accumulators.
// - Not-equal and sign flags follow every accumulator write.
// - Carry and overflow change only on calculating operations.
// - Each flag can condition a jump.
// - Carry holds add/sub carry or the bit shifted out.
// - Nonzero result drives not-equal flag to zero.
// - Sign flag set when result MSB is one.
// - Overflow flags signed two's complement overflow of add or sub.
// - RAM from word 112 up may be reused by built-in routines.
// - Arithmetic combines two accumulators, result into first named.
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
module cpu_datapath
  import cpu_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_strobe,
  input  wire logic        rd_strobe,
  output logic [31:0]      rdata,
  output logic [PCW-1:0]   pc,
  output logic             running
);
  typedef struct packed {
    phase_t          phase;
    logic [3:0]      boot_idx;
    logic [DW-1:0]   x;
    logic [DW-1:0]   y;
    logic [DW-1:0]   z;
    logic [6:0]      ptr;
    logic [PCW-1:0]  pc;
    logic [PCW-1:0]  ret;
    logic            carry;
    logic            ne;
    logic            sign;
    logic            ovf;
    logic            rom_ret_en;
    logic            running;
    logic [DW-1:0]   opnd;
    logic [31:0]     rdata;
  } state_t;

  state_t          state;
  state_t          next_state;
  logic [DW-1:0]   ram [RAM_WORDS];
  logic [7:0]      nvm [NVM_BYTES];
  logic            ram_we;
  logic [6:0]      ram_wa;
  logic [DW-1:0]   ram_wd;
  logic            nvm_we;
  logic [10:0]     nvm_ra;
  logic [DW-1:0]   nvm_word;
  logic            cmd_go;
  op_t             op;
  logic [1:0]      dst;
  logic [1:0]      src;
  logic [1:0]      cond;
  logic [PCW-1:0]  arg;
  logic [DW-1:0]   opa;
  logic [DW-1:0]   opb;
  logic [DW-1:0]   res;
  logic            alu_c;
  logic            alu_v;
  logic            alu_wr;
  logic            alu_cv;
  logic            flag_hit;
  logic            in_rom;
  logic            in_code;
  logic [DW-1:0]   status_old;
  logic [DW-1:0]   ptr_word;
  logic [DW:0]     add_chk;

  // Pointed word comes in as an argument so callers follow RAM writes
  function automatic logic [DW-1:0] acc(input logic [1:0] sel, input state_t s,
                                        input logic [DW-1:0] pw);
    case (sel)
      2'd0:    acc = s.x;
      2'd1:    acc = s.y;
      2'd2:    acc = s.z;
      default: acc = pw;
    endcase
  endfunction

  // Transfers out of the routine area always land on the program entry
  function automatic logic [PCW-1:0] land(input logic [PCW-1:0] t, input logic rom);
    land = (rom && t < ROM_BASE) ? PROG_ENTRY : t;
  endfunction

  assign cmd_go     = wr_strobe && addr == REG_CMD && state.phase == ST_RUN;
  assign op         = op_t'(wdata[4:0]);
  assign dst        = wdata[CMD_DST_LSB +: 2];
  assign src        = wdata[CMD_SRC_LSB +: 2];
  assign cond       = wdata[CMD_COND_LSB +: 2];
  assign arg        = wdata[CMD_ARG_LSB +: PCW];
  assign in_rom     = state.pc >= ROM_BASE;
  assign in_code    = (arg >= PROG_ENTRY && arg < CODE_END) ||
                      (arg >= ROM_BASE && arg <= ROM_TOP);
  assign status_old = ram[STATUS_ADDR];
  // Configuration words during boot, user cells by index at run time
  assign nvm_ra     = (state.phase == ST_RUN) ?
                      11'(USER_NVM_BASE + 11'(3 * arg[3:0])) :
                      11'(3 * state.boot_idx);
  assign nvm_word   = {nvm[nvm_ra], nvm[11'(nvm_ra + 11'd1)], nvm[11'(nvm_ra + 11'd2)]};
  assign ptr_word   = ram[state.ptr];
  assign opa        = acc(dst, state, ptr_word);
  assign opb        = (op == OP_LOAD) ? state.opnd :
                      (op == OP_NVM_GET) ? nvm_word : acc(src, state, ptr_word);
  // Independent carry reference for the add check
  assign add_chk    = {1'b0, opa} + {1'b0, opb};

  always_comb begin
    case (cond)
      2'd0:    flag_hit = state.carry;
      2'd1:    flag_hit = state.ne;
      2'd2:    flag_hit = state.sign;
      default: flag_hit = state.ovf;
    endcase
  end

  alu_core u_alu (
    .op         (op),
    .a          (opa),
    .b          (opb),
    .carry_in   (state.carry),
    .res        (res),
    .carry_out  (alu_c),
    .ovf_out    (alu_v),
    .writes_acc (alu_wr),
    .updates_cv (alu_cv)
  );

  always_comb begin
    next_state = state;
    ram_we     = 1'b0;
    ram_wa     = state.ptr;
    ram_wd     = '0;
    nvm_we     = 1'b0;
    next_state.rdata = 32'h0000_0000;
    if (rd_strobe) begin
      case (addr)
        REG_OPND:    next_state.rdata = {8'h00, state.opnd};
        REG_STAT:    next_state.rdata = {7'h00, state.running, state.pc, state.ptr,
                                         state.ovf, state.sign, state.ne, state.carry};
        REG_CTRL:    next_state.rdata = {31'h0, state.rom_ret_en};
        REG_ACC_X:   next_state.rdata = {8'h00, state.x};
        REG_ACC_Y:   next_state.rdata = {8'h00, state.y};
        REG_ACC_Z:   next_state.rdata = {8'h00, state.z};
        REG_ACC_RAM: next_state.rdata = {8'h00, ram[state.ptr]};
        default:     next_state.rdata = 32'h0000_0000;
      endcase
    end
    if (wr_strobe && addr == REG_OPND) begin
      next_state.opnd = wdata[DW-1:0];
    end
    if (wr_strobe && addr == REG_CTRL) begin
      next_state.rom_ret_en = wdata[0];
    end
    case (state.phase)
      ST_COPY: begin
        ram_we = 1'b1;
        ram_wa = (state.boot_idx < CFG_LOW_COUNT) ?
                 7'(CFG_RAM_BASE + 7'(state.boot_idx)) :
                 7'(CFG_HIGH_RAM + 7'(state.boot_idx - CFG_LOW_COUNT));
        ram_wd = nvm_word;
        next_state.boot_idx = 4'(state.boot_idx + 4'd1);
        if (state.boot_idx == CFG_LAST) begin
          next_state.phase = ST_FLAG;
        end
      end
      ST_FLAG: begin
        ram_we = 1'b1;
        ram_wa = STATUS_ADDR;
        ram_wd = {status_old[DW-1:CAUSE_LSB+5], CAUSE_POR, status_old[CAUSE_LSB-1:0]};
        next_state.pc      = PROG_ENTRY;
        next_state.running = 1'b1;
        next_state.phase   = ST_RUN;
      end
      ST_RUN: begin
        if (cmd_go) begin
          if (alu_wr) begin
            case (dst)
              2'd0:    next_state.x = res;
              2'd1:    next_state.y = res;
              2'd2:    next_state.z = res;
              default: begin
                ram_we = 1'b1;
                ram_wd = res;
              end
            endcase
            if (op == OP_SWAP) begin
              case (src)
                2'd0:    next_state.x = opa;
                2'd1:    next_state.y = opa;
                2'd2:    next_state.z = opa;
                default: begin
                  ram_we = 1'b1;
                  ram_wd = opa;
                end
              endcase
            end
            next_state.ne   = (res == '0);
            next_state.sign = res[DW-1];
            if (alu_cv) begin
              next_state.carry = alu_c;
              next_state.ovf   = alu_v;
            end
          end
          case (op)
            OP_PTR_LOAD: next_state.ptr = arg[6:0];
            OP_PTR_INC:  next_state.ptr = 7'(state.ptr + 7'd1);
            OP_PTR_DEC:  next_state.ptr = 7'(state.ptr - 7'd1);
            OP_JUMP: begin
              if (in_code) begin
                next_state.pc = land(arg, in_rom);
              end
            end
            OP_JCOND: begin
              if (in_code && flag_hit) begin
                next_state.pc = land(arg, in_rom);
              end
            end
            OP_CALL: begin
              if (in_code) begin
                next_state.ret = state.pc;
                next_state.pc  = land(arg, in_rom);
              end
            end
            OP_RET: begin
              if (!in_rom || state.ret >= ROM_BASE) begin
                next_state.pc = state.ret;
              end else if (state.rom_ret_en) begin
                next_state.pc = PROG_ENTRY;
              end
            end
            OP_ENTER: begin
              next_state.pc = PROG_ENTRY;
              ram_we = 1'b1;
              ram_wa = STATUS_ADDR;
              ram_wd = {status_old[DW-1:CAUSE_LSB+5], arg[4:0],
                        status_old[CAUSE_LSB-1:0]};
            end
            OP_NVM_PUT: nvm_we = 1'b1;
            default: ;
          endcase
        end
      end
      default: next_state.phase = ST_COPY;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // RAM words from SCRATCH_BASE up carry no protection: built-in
  // routines may clobber them, so software keeps nothing there.
  always_ff @(posedge clock) begin
    if (ram_we) begin
      ram[ram_wa] <= ram_wd;
    end
  end

  // Byte store sits in a plain clocked process: its configuration bytes
  // are preloaded from outside at start-up, which an always_ff forbids
  always @(posedge clock) begin
    if (nvm_we) begin
      nvm[nvm_ra]              <= opb[23:16];
      nvm[11'(nvm_ra + 11'd1)] <= opb[15:8];
      nvm[11'(nvm_ra + 11'd2)] <= opb[7:0];
    end
  end

  assign rdata   = state.rdata;
  assign pc      = state.pc;
  assign running = state.running;

  a_boot_copy_end: assert property (@(posedge clock) disable iff (sys_rst)
    state.phase == ST_COPY && state.boot_idx == CFG_LAST |=> state.phase == ST_FLAG)
    else $error("copy did not end after sixteen words");

  a_boot_entry_pc: assert property (@(posedge clock) disable iff (sys_rst)
    state.phase == ST_FLAG |=> running && pc == PROG_ENTRY && !$past(running))
    else $error("fetch began before copy finished");

  a_rom_exit_lands: assert property (@(posedge clock) disable iff (sys_rst)
    cmd_go && op == OP_JUMP && in_code && in_rom && arg < ROM_BASE
    |=> pc == PROG_ENTRY)
    else $error("exit from routine area missed entry");

  a_rom_call_reach: assert property (@(posedge clock) disable iff (sys_rst)
    cmd_go && op == OP_CALL && arg >= ROM_BASE && arg <= ROM_TOP
    |=> pc == $past(arg) && state.ret == $past(state.pc))
    else $error("call into routine area failed");

  a_rom_call_exit: assert property (@(posedge clock) disable iff (sys_rst)
    cmd_go && op == OP_CALL && in_code && in_rom && arg < ROM_BASE
    |=> pc == PROG_ENTRY)
    else $error("call from routine area missed entry");

  a_ptr_keeps_ram: assert property (@(posedge clock) disable iff (sys_rst)
    cmd_go && (op == OP_PTR_INC || op == OP_PTR_DEC || op == OP_PTR_LOAD)
    |-> !ram_we)
    else $error("pointer change touched RAM");

  a_ptr_only_ops: assert property (@(posedge clock) disable iff (sys_rst)
    !(cmd_go && (op == OP_PTR_INC || op == OP_PTR_DEC || op == OP_PTR_LOAD))
    |=> state.ptr == $past(state.ptr))
    else $error("pointer moved without a pointer command");

  a_ne_sign_flags: assert property (@(posedge clock) disable iff (sys_rst)
    cmd_go && alu_wr |=> state.ne == ($past(res) == '0) && state.sign == $past(res[DW-1]))
    else $error("not-equal or sign flag wrong");

  a_cv_flags_hold: assert property (@(posedge clock) disable iff (sys_rst)
    cmd_go && !alu_cv |=> $stable(state.carry) && $stable(state.ovf))
    else $error("carry or overflow changed without calculation");

  a_add_carry_out: assert property (@(posedge clock) disable iff (sys_rst)
    cmd_go && op == OP_ADD |=> state.carry == $past(add_chk[DW]))
    else $error("carry after add wrong");

  a_read_one_cycle: assert property (@(posedge clock) disable iff (sys_rst)
    !rd_strobe |=> rdata == 32'h0000_0000)
    else $error("read data outside its cycle");
endmodule

/* File: verif/cpu_memory_map_alu_flags_bench.sv */
// Self-checking bench for the core datapath: power-on copy, address map,
// pointer, accumulators and flags, all reached through the register port.
// Assumes the datapath keeps its byte store in an array named nvm.
`timescale 1ns/10ps
module cpu_memory_map_alu_flags_bench;
  import cpu_pkg::*;
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end

  logic              clock;
  logic              sys_rst;
  logic [7:0]        addr;
  logic [31:0]       wdata;
  logic              wr_strobe;
  logic              rd_strobe;
  logic [31:0]       rdata;
  logic [PCW-1:0]    pc;
  logic              running;
  int                errors;
  int                checks;
  int                cycles;
  logic              rd_q;
  logic [31:0]       exp_q[$];
  logic [31:0]       mask_q[$];
  logic [31:0]       seed;
  logic [23:0]       m[4];
  logic              c_m, ne_m, s_m, v_m;
  logic [12:0]       pc_m;
  logic [6:0]        ptr_m;
  logic [7:0]        img[48];

  cpu_datapath u_dut (.clock(clock), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
                      .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata),
                      .pc(pc), .running(running));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic complete_run();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Result watcher: the read answer stands only in the cycle after the strobe
  always @(posedge clock) begin
    logic [31:0] mk;
    logic [31:0] ex;
    if (rd_q) begin
      mk = mask_q.pop_front();
      ex = exp_q.pop_front();
      `CHK(rdata & mk, ex)
    end
    rd_q <= rd_strobe;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 10000) begin
      errors++;
      complete_run();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  function logic [23:0] rnd();
    seed = lfsr(seed);
    return seed[23:0];
  endfunction

  task automatic drive(input logic [7:0] a, input logic [31:0] d, input logic w, input logic r);
    addr <= a;
    wdata <= d;
    wr_strobe <= w;
    rd_strobe <= r;
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    drive(a, d, 1'b1, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] mk);
    exp_q.push_back(e & mk);
    mask_q.push_back(mk);
    drive(a, 32'h0, 1'b0, 1'b1);
  endtask

  task automatic cmd(input op_t o, input logic [1:0] d, input logic [1:0] s,
                     input logic [1:0] cnd, input logic [12:0] arg);
    wr(REG_CMD, {8'h00, arg, cnd, s, d, o});
  endtask

  task set_nz(input logic [23:0] r);
    ne_m = (r == 24'h0);
    s_m = r[23];
  endtask

  task chk_acc(input logic [1:0] i);
    rd({4'h1, i, 2'b00}, {8'h00, m[i]}, 32'hFFFFFFFF);
  endtask

  task chk_stat();
    rd(REG_STAT, {7'h00, 1'b1, pc_m, ptr_m, v_m, s_m, ne_m, c_m}, 32'hFFFFFFFF);
  endtask

  task ld(input logic [1:0] d, input logic [23:0] val);
    wr(REG_OPND, {8'h00, val});
    cmd(OP_LOAD, d, 2'd0, 2'd0, 13'h0000);
    m[d] = val;
    set_nz(val);
  endtask

  task setptr(input logic [6:0] p);
    cmd(OP_PTR_LOAD, 2'd0, 2'd0, 2'd0, {6'h00, p});
    ptr_m = p;
  endtask

  task alu(input op_t o, input logic [1:0] d, input logic [1:0] s);
    logic [24:0] t;
    logic [23:0] a, b, r;
    logic [47:0] p;
    a = m[d];
    b = m[s];
    case (o)
      OP_MOVE: r = b;
      OP_SWAP: begin
        r = b;
        m[s] = a;
      end
      OP_ADD, OP_SUB: begin
        t = (o == OP_ADD) ? {1'b0, a} + {1'b0, b} : {1'b0, a} - {1'b0, b};
        r = t[23:0];
        c_m = t[24];
        v_m = ((a[23] ^ b[23]) == (o == OP_SUB)) && (r[23] != a[23]);
      end
      shift_left_op: begin
        r = {a[22:0], 1'b0};
        c_m = a[23];
        v_m = 1'b0;
      end
      shift_right_op, rotate_right_op: begin
        r = {(o == shift_right_op) ? a[23] : a[0], a[23:1]};
        c_m = a[0];
        v_m = 1'b0;
      end
      default: begin
        p = a * b;
        r = p[23:0];
      end
    endcase
    cmd(o, d, s, 2'd0, 13'h0000);
    m[d] = r;
    set_nz(r);
  endtask

  // Releases reset, checks the copy length, the dropped early command and the copied words
  task por_check();
    int n;
    sys_rst <= 1'b0;
    cmd(OP_PTR_LOAD, 2'd0, 2'd0, 2'd0, 13'h007F);
    n = 1;
    #1;
    while (running !== 1'b1 && n < 40) begin
      drive(8'h00, 32'h0, 1'b0, 1'b0);
      n++;
      #1;
    end
    // Sixteen copy cycles, then one status write before running rises
    `CHK(n, int'(CFG_LAST) + 2)
    `CHK(pc, PROG_ENTRY)
    pc_m = PROG_ENTRY;
    rd(REG_STAT, {7'h00, 1'b1, PROG_ENTRY, 7'h00, 4'h0}, 32'h01FFFFF0);
    setptr(STATUS_ADDR);
    rd(REG_ACC_RAM, 32'h00080000, 32'hFF0F8000);
    for (int k = 0; k < 16; k++) begin
      setptr(k < 13 ? CFG_RAM_BASE + 7'(k) : CFG_HIGH_RAM + 7'(k - 13));
      rd(REG_ACC_RAM, {8'h00, img[3*k], img[3*k+1], img[3*k+2]}, 32'hFFFFFFFF);
    end
  endtask

  initial begin
    op_t ops[8];
    op_t o;
    logic [23:0] a, b, va, vb;
    logic [3:0] fl;
    logic [12:0] tgt;
    ops = '{OP_ADD, OP_SUB, OP_MOVE, OP_SWAP, shift_left_op, shift_right_op,
            rotate_right_op, multiply_single_width_op};
    sys_rst = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    wr_strobe = 1'b0;
    rd_strobe = 1'b0;
    rd_q = 1'b0;
    errors = 0;
    checks = 0;
    cycles = 0;
    seed = 32'hF897A7CF;
    for (int i = 0; i < 48; i++) begin
      seed = lfsr(seed);
      img[i] = seed[7:0];
      u_dut.nvm[i] = img[i];
    end
    repeat (20) @(posedge clock);
    por_check();
    setptr(7'h64);
    for (int i = 0; i < 40; i++) begin
      o = ops[i % 8];
      a = rnd();
      b = (i % 16 == 1) ? a : rnd();
      if (o == rotate_right_op) a[0] = c_m;
      ld(2'(i), a);
      ld(2'(i + 1), b);
      alu(o, 2'(i), 2'(i + 1));
      chk_acc(2'(i));
      if (o == OP_SWAP) chk_acc(2'(i + 1));
      chk_stat();
      fl = {v_m, s_m, ne_m, c_m};
      tgt = 13'h00C8 + 13'(i);
      if (fl[i % 4]) pc_m = tgt;
      cmd(OP_JCOND, 2'd0, 2'd0, 2'(i), tgt);
      chk_stat();
    end
    va = rnd();
    ld(2'd3, va);
    cmd(OP_PTR_INC, 2'd0, 2'd0, 2'd0, 13'h0000);
    ptr_m++;
    ld(2'd3, rnd());
    cmd(OP_PTR_DEC, 2'd0, 2'd0, 2'd0, 13'h0000);
    ptr_m--;
    m[3] = va;
    chk_acc(2'd3);
    chk_stat();
    setptr(7'h7F);
    ld(2'd3, rnd());
    chk_acc(2'd3);
    va = rnd();
    vb = rnd();
    ld(2'd0, va);
    cmd(OP_NVM_PUT, 2'd0, 2'd0, 2'd0, 13'h0000);
    ld(2'd0, vb);
    cmd(OP_NVM_PUT, 2'd0, 2'd0, 2'd0, 13'h000F);
    cmd(OP_NVM_GET, 2'd1, 2'd0, 2'd0, 13'h000F);
    cmd(OP_NVM_GET, 2'd2, 2'd0, 2'd0, 13'h0000);
    m[1] = vb;
    m[2] = va;
    set_nz(va);
    chk_acc(2'd1);
    chk_acc(2'd2);
    chk_stat();
    wr(REG_CTRL, 32'h0);
    cmd(OP_CALL, 2'd0, 2'd0, 2'd0, ROM_BASE);
    pc_m = ROM_BASE;
    chk_stat();
    cmd(OP_RET, 2'd0, 2'd0, 2'd0, 13'h0000);
    cmd(OP_JUMP, 2'd0, 2'd0, 2'd0, ROM_TOP + 13'h0001);
    chk_stat();
    wr(REG_CTRL, 32'h1);
    rd(REG_CTRL, 32'h1, 32'h1);
    cmd(OP_RET, 2'd0, 2'd0, 2'd0, 13'h0000);
    pc_m = PROG_ENTRY;
    chk_stat();
    cmd(OP_CALL, 2'd0, 2'd0, 2'd0, ROM_TOP);
    cmd(OP_CALL, 2'd0, 2'd0, 2'd0, 13'h01F4);
    chk_stat();
    cmd(OP_CALL, 2'd0, 2'd0, 2'd0, ROM_TOP);
    cmd(OP_JUMP, 2'd0, 2'd0, 2'd0, 13'h01F4);
    chk_stat();
    cmd(OP_JUMP, 2'd0, 2'd0, 2'd0, CODE_END);
    cmd(OP_JUMP, 2'd0, 2'd0, 2'd0, 13'h002F);
    chk_stat();
    cmd(OP_JUMP, 2'd0, 2'd0, 2'd0, CODE_END - 13'h0001);
    pc_m = CODE_END - 13'h0001;
    chk_stat();
    cmd(OP_ENTER, 2'd0, 2'd0, 2'd0, 13'h0005);
    pc_m = PROG_ENTRY;
    setptr(STATUS_ADDR);
    rd(REG_ACC_RAM, 32'h00028000, 32'hFF0F8000);
    chk_stat();
    wr(REG_OPND, 32'hFFFFFFFF);
    rd(REG_OPND, 32'h00FFFFFF, 32'hFFFFFFFF);
    rd(8'h20, 32'h0, 32'hFFFFFFFF);
    drive(8'h00, 32'h0, 1'b0, 1'b0);
    sys_rst <= 1'b1;
    repeat (3) drive(8'h00, 32'h0, 1'b0, 1'b0);
    por_check();
    repeat (3) drive(8'h00, 32'h0, 1'b0, 1'b0);
    complete_run();
  end
endmodule
